// ---- common/sdrc_pkg.sv ----
// ****************************************************************
// sampling delay and ramp control: shared constants and types
// ****************************************************************
package sdrc_pkg;

	// ************************************************************
	// widths and counts
	// ************************************************************
	localparam int DELAY_W = 8; // 256 selectable values per delay
	localparam int RAMP_WINDOW = 256; // device clock cycles per window
	localparam int SLOW_STEPS = 1; // coarse steps per window, slow
	localparam int FAST_STEPS = 4; // coarse steps per window, fast
	localparam int TIMER_W = 8;
	// cycles between two coarse steps, stored as last timer value
	localparam logic [TIMER_W-1:0] SLOW_LAST =
		TIMER_W'(RAMP_WINDOW / SLOW_STEPS - 1);
	localparam logic [TIMER_W-1:0] FAST_LAST =
		TIMER_W'(RAMP_WINDOW / FAST_STEPS - 1);
	localparam int SYNC_STAGES = 3; // pin synchroniser depth

	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic [DELAY_W-1:0] COARSE_RST = 8'h00;
	localparam logic [DELAY_W-1:0] FINE_RST = 8'h00;
	localparam logic INV_RST = 1'b0;
	localparam logic [TIMER_W-1:0] TIMER_RST = 8'h00;

	// ************************************************************
	// types
	// ************************************************************
	// link mode: dual-channel samples rising edge only
	typedef enum logic {
		SDRC_MODE_DUAL = 1'b0,
		SDRC_MODE_SINGLE = 1'b1
	} sdrc_mode_t;

	// ramp rate select
	typedef enum logic {
		SDRC_RATE_SLOW = 1'b0,
		SDRC_RATE_FAST = 1'b1
	} sdrc_rate_t;

	// ramp state, gray coded
	typedef enum logic [1:0] {
		SDRC_ST_IDLE = 2'b00,
		SDRC_ST_RAMP = 2'b01
	} sdrc_state_t;

	// the aperture delay actually applied to the internal clocks
	typedef struct packed {
		logic inv;
		logic [DELAY_W-1:0] coarse;
		logic [DELAY_W-1:0] fine;
	} sdrc_delay_t;

	// edge enables handed to the sampling and digital paths
	typedef struct packed {
		logic rise_en;
		logic fall_en;
		logic proc_en;
	} sdrc_edges_t;

endpackage : sdrc_pkg

// ---- hdl/sdrc_ctrl.sv ----
`timescale 1ns/1ps

// ****************************************************************
// sampling edge select, aperture delay and coarse ramp control
// ****************************************************************
module sdrc_ctrl (
	input wire logic clock, // device clock, 100 MHz
	input wire logic rst, // synchronous reset, high
	input wire logic clk_en, // freezes all state but the update and capture pulses while low
	input wire logic link_mode_select, // 0 dual-channel, 1 single
	input wire logic clock_invert_delay, // invert device clock
	input wire logic [7:0] coarse_delay_setting, // coarse target
	input wire logic coarse_wr, // one-cycle write of coarse value
	input wire logic [7:0] fine_delay_setting, // fine delay value
	input wire logic ramp_enable_bit, // ramp coarse writes
	input wire logic ramp_step_rate, // 0 slow, 1 fast
	input wire logic sysref_pin, // system reference, asynchronous
	output sdrc_pkg::sdrc_edges_t edges, // sampling edge enables
	output sdrc_pkg::sdrc_delay_t applied_delay, // delay in force
	output logic [7:0] coarse_target, // last written coarse value
	output logic ramp_busy, // ramp still moving
	output logic delay_update, // pulse: applied delay changed
	output logic sysref_capture, // pulse: reference edge taken
	output logic sysref_level // filtered reference level
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		sdrc_pkg::sdrc_state_t state;
		sdrc_pkg::sdrc_delay_t cur;
		logic [sdrc_pkg::DELAY_W-1:0] target;
		logic [sdrc_pkg::TIMER_W-1:0] timer;
		sdrc_pkg::sdrc_edges_t edges;
		logic update;
		logic capture;
	} sdrc_ctrl_st_t;

	sdrc_ctrl_st_t st_reg;
	sdrc_ctrl_st_t st_next;
	logic ref_rise;
	logic ref_level;

	// last timer value before the next coarse step
	function automatic logic [sdrc_pkg::TIMER_W-1:0] step_last(
		input logic rate
	);
		if (rate == sdrc_pkg::SDRC_RATE_FAST) begin
			return sdrc_pkg::FAST_LAST;
		end
		return sdrc_pkg::SLOW_LAST;
	endfunction : step_last

	// one coarse step toward the target, never past it
	function automatic logic [sdrc_pkg::DELAY_W-1:0] step_toward(
		input logic [sdrc_pkg::DELAY_W-1:0] cur,
		input logic [sdrc_pkg::DELAY_W-1:0] tgt
	);
		if (tgt > cur) begin
			return sdrc_pkg::DELAY_W'(cur + 1'b1);
		end
		if (tgt < cur) begin
			return sdrc_pkg::DELAY_W'(cur - 1'b1);
		end
		return cur;
	endfunction : step_toward

	// ************************************************************
	// reference input
	// ************************************************************
	// the pin is foreign to the clock, so it is filtered first
	sdrc_sync u_ref_sync (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.pin_in(sysref_pin),
		.level_out(ref_level),
		.rise_out(ref_rise)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.update = 1'b0;
		st_next.capture = 1'b0;
		if (clk_en) begin
			// rising edge always samples; both edges in single mode
			st_next.edges.rise_en = 1'b1;
			st_next.edges.fall_en =
				(link_mode_select == sdrc_pkg::SDRC_MODE_SINGLE);
			st_next.edges.proc_en = 1'b1;
			// reference taken on the rising edge after the filter
			st_next.capture = ref_rise;
			// inversion and fine act on their own, at any time
			st_next.cur.inv = clock_invert_delay;
			st_next.cur.fine = fine_delay_setting;
			case (st_reg.state)
				sdrc_pkg::SDRC_ST_IDLE: begin
					st_next.timer = sdrc_pkg::TIMER_RST;
				end
				sdrc_pkg::SDRC_ST_RAMP: begin
					if (st_reg.cur.coarse == st_reg.target) begin
						st_next.state = sdrc_pkg::SDRC_ST_IDLE;
						st_next.timer = sdrc_pkg::TIMER_RST;
					end else if (st_reg.timer == step_last(ramp_step_rate)) begin
						// one step per interval keeps clock glitches small
						st_next.cur.coarse =
							step_toward(st_reg.cur.coarse, st_reg.target);
						st_next.timer = sdrc_pkg::TIMER_RST;
					end else begin
						st_next.timer =
							sdrc_pkg::TIMER_W'(st_reg.timer + 1'b1);
					end
				end
				default: begin
					st_next.state = sdrc_pkg::SDRC_ST_IDLE;
					st_next.timer = sdrc_pkg::TIMER_RST;
				end
			endcase
			// a new write wins over any ramp in progress
			if (coarse_wr) begin
				st_next.target = coarse_delay_setting;
				st_next.timer = sdrc_pkg::TIMER_RST;
				if (ramp_enable_bit) begin
					st_next.state = sdrc_pkg::SDRC_ST_RAMP;
					st_next.cur.coarse = st_reg.cur.coarse;
				end else begin
					st_next.state = sdrc_pkg::SDRC_ST_IDLE;
					st_next.cur.coarse = coarse_delay_setting;
				end
			end
			// live changes are taken; the pulse warns the link side
			st_next.update = (st_next.cur != st_reg.cur);
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			st_reg.state <= sdrc_pkg::SDRC_ST_IDLE;
			st_reg.cur.inv <= sdrc_pkg::INV_RST;
			st_reg.cur.coarse <= sdrc_pkg::COARSE_RST;
			st_reg.cur.fine <= sdrc_pkg::FINE_RST;
			st_reg.target <= sdrc_pkg::COARSE_RST;
			st_reg.timer <= sdrc_pkg::TIMER_RST;
			st_reg.edges <= '0;
			st_reg.update <= 1'b0;
			st_reg.capture <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// all three delays travel together to every internal clock
	assign applied_delay = st_reg.cur;
	assign edges = st_reg.edges;
	assign coarse_target = st_reg.target;
	assign ramp_busy = (st_reg.state == sdrc_pkg::SDRC_ST_RAMP);
	assign delay_update = st_reg.update;
	assign sysref_capture = st_reg.capture;
	assign sysref_level = ref_level;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// the edge that releases reset still loads reset values, so skip it
	a_dual_rise_only: assert property (
		!rst && clk_en && link_mode_select == 1'b0 |=>
			edges.rise_en && !edges.fall_en)
		else $error("dual mode must sample on rising edge only");

	a_single_both: assert property (
		!rst && clk_en && link_mode_select == 1'b1 |=>
			edges.rise_en && edges.fall_en)
		else $error("single mode must sample on both edges");

	a_proc_enabled: assert property (
		!rst && clk_en ##1 clk_en |-> edges.proc_en && edges.rise_en)
		else $error("processing path not clocked");

	a_capture_edge: assert property (
		sysref_capture |-> $past(clk_en) && sysref_level
			&& !$past(sysref_level, 2))
		else $error("reference captured without a filtered rise");

	a_inv_follow: assert property (
		clk_en |=> applied_delay.inv == $past(clock_invert_delay))
		else $error("inversion not applied");

	a_fine_indep: assert property (
		clk_en && !coarse_wr && !ramp_busy |=>
			applied_delay.fine == $past(fine_delay_setting)
			&& $stable(applied_delay.coarse))
		else $error("fine change disturbed coarse");

	a_direct_write: assert property (
		clk_en && coarse_wr && !ramp_enable_bit |=>
			applied_delay.coarse == $past(coarse_delay_setting)
			&& !ramp_busy)
		else $error("direct coarse write not applied");

	a_ramp_start: assert property (
		clk_en && coarse_wr && ramp_enable_bit |=>
			coarse_target == $past(coarse_delay_setting) && ramp_busy
			&& $stable(applied_delay.coarse))
		else $error("ramp did not start on coarse write");

	a_ramp_unit: assert property (
		ramp_busy && !$past(coarse_wr) && $changed(applied_delay.coarse)
			|-> applied_delay.coarse == $past(applied_delay.coarse) + 8'h01
			|| applied_delay.coarse == $past(applied_delay.coarse) - 8'h01)
		else $error("ramp moved more than one coarse step");

	a_fast_spacing: assert property (
		ramp_busy && $changed(applied_delay.coarse) && !$past(coarse_wr)
			&& $past(ramp_step_rate)
			|-> $past(st_reg.timer) == sdrc_pkg::FAST_LAST)
		else $error("fast ramp step at wrong time");

	a_slow_spacing: assert property (
		ramp_busy && $changed(applied_delay.coarse) && !$past(coarse_wr)
			&& !$past(ramp_step_rate)
			|-> $past(st_reg.timer) == sdrc_pkg::SLOW_LAST)
		else $error("slow ramp step at wrong time");

	a_update_flag: assert property (
		$changed(applied_delay) |-> delay_update)
		else $error("delay change not flagged");

	c_ramp_done: cover property (
		ramp_busy ##1 !ramp_busy);

	c_direct_write: cover property (
		clk_en && coarse_wr && !ramp_enable_bit);

	c_single_capture: cover property (
		sysref_capture && edges.fall_en);

	c_retarget: cover property (
		ramp_busy && coarse_wr && ramp_enable_bit);

endmodule : sdrc_ctrl

// ---- hdl/sdrc_sync.sv ----
`timescale 1ns/1ps
// ****************************************************************
// three-stage pin synchroniser with agreement filter
// ****************************************************************
module sdrc_sync (
	input wire logic clock, // device clock
	input wire logic rst, // synchronous reset, high
	input wire logic clk_en, // freezes all state but the rise pulse while low
	input wire logic pin_in, // asynchronous pin level
	output logic level_out, // filtered level
	output logic rise_out // one-cycle pulse on accepted rise
);

	typedef struct packed {
		logic [sdrc_pkg::SYNC_STAGES-1:0] stage;
		logic level;
		logic rise;
	} sdrc_sync_st_t;

	sdrc_sync_st_t st_reg;
	sdrc_sync_st_t st_next;

	// ************************************************************
	// next state
	// ************************************************************
	// first stage feeds only the second; level moves when 2 and 3 agree
	always_comb begin
		st_next = st_reg;
		st_next.rise = 1'b0;
		if (clk_en) begin
			st_next.stage = {st_reg.stage[1:0], pin_in};
			if (st_reg.stage[1] == st_reg.stage[2]) begin
				st_next.level = st_reg.stage[2];
				st_next.rise = st_reg.stage[2] & ~st_reg.level;
			end
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level_out = st_reg.level;
	assign rise_out = st_reg.rise;

endmodule : sdrc_sync

// ---- test/sdrc_sysref_gen.sv ----
`timescale 1ns/1ps
// ****************************************************************
// external clock source model: system reference generator
// ****************************************************************
module sdrc_sysref_gen #(
	parameter int MF_CYCLES = 32, // local multiframe length in clocks
	parameter int DIV = 1 // integer division of the multiframe clock
) (
	input wire logic clock, // device clock
	input wire logic rst, // synchronous reset, high
	input wire logic fire, // request one single reference pulse
	input wire logic periodic, // run the reference continuously
	output logic sysref_pin // reference to the device, asynchronous
);
	localparam int PERIOD = MF_CYCLES * DIV;
	int cnt;

	// edges land 3 ns after the clock so the reference is not aligned
	always @(posedge clock) begin
		if (rst) begin
			cnt <= 0;
			sysref_pin <= #3 1'b0;
		end else if (periodic) begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			sysref_pin <= #3 (cnt < PERIOD / 2);
		end else if (fire) begin
			cnt <= 8; // single pulse, eight clocks high
			sysref_pin <= #3 1'b1;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				sysref_pin <= #3 1'b0;
			end
		end
	end
endmodule : sdrc_sysref_gen

// ---- test/test_sampling_delay_ramp_control.sv ----
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench for the sampling delay and ramp control
// ****************************************************************
module test_sampling_delay_ramp_control;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic mode = 1'b0;
	logic inv = 1'b0;
	logic [7:0] coarse = 8'h00;
	logic wr = 1'b0;
	logic [7:0] fine = 8'h00;
	logic ramp_en = 1'b0;
	logic rate = 1'b0;
	logic fire = 1'b0;
	logic periodic = 1'b0;
	logic sysref_pin;
	sdrc_pkg::sdrc_edges_t edges;
	sdrc_pkg::sdrc_delay_t applied_delay;
	logic [7:0] coarse_target;
	logic ramp_busy;
	logic delay_update;
	logic sysref_capture;
	logic sysref_level;
	int mismatches = 0;
	int n_tests = 0;

	sdrc_ctrl uut (.clock(clock), .rst(rst), .clk_en(clk_en),
		.link_mode_select(mode), .clock_invert_delay(inv),
		.coarse_delay_setting(coarse), .coarse_wr(wr),
		.fine_delay_setting(fine), .ramp_enable_bit(ramp_en),
		.ramp_step_rate(rate), .sysref_pin(sysref_pin), .edges(edges),
		.applied_delay(applied_delay), .coarse_target(coarse_target),
		.ramp_busy(ramp_busy), .delay_update(delay_update),
		.sysref_capture(sysref_capture), .sysref_level(sysref_level));

	sdrc_sysref_gen gen (.clock(clock), .rst(rst), .fire(fire),
		.periodic(periodic), .sysref_pin(sysref_pin));

	// 100 MHz device clock
	initial begin
		forever #5 clock = ~clock;
	end

	// ************************************************************
	// shared helpers
	// ************************************************************
	task check_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit

	task check_vec(input string what, input logic [16:0] exp,
		input logic [16:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check_vec

	// sample 1 ns after the edge so that edge's updates have landed
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	// one-cycle write; returns one cycle after the taking edge
	task wr_coarse(input logic [7:0] v, input logic ramp, input logic r);
		@(posedge clock);
		coarse <= v;
		ramp_en <= ramp;
		rate <= r;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		tick(1);
	endtask : wr_coarse

	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// ************************************************************
	// scenarios
	// ************************************************************
	task reset_edges_test;
		// release at the eighth edge; that edge still loads reset values
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		#1;
		check_vec("delay in reset", 17'h00000, applied_delay);
		check_bit("busy in reset", 1'b0, ramp_busy);
		tick(2);
		check_vec("dual edges", 17'(3'b101), 17'(edges));
		@(posedge clock);
		mode <= 1'b1;
		tick(2);
		check_vec("single edges", 17'(3'b111), 17'(edges));
		$display("reset_edges_test done");
	endtask : reset_edges_test

	task delay_test;
		@(posedge clock);
		fine <= 8'hff;
		inv <= 1'b1;
		// taken at the next edge; the update pulse stands one cycle
		tick(1);
		check_vec("inv fine", 17'h100ff, applied_delay);
		check_bit("update", 1'b1, delay_update);
		tick(1);
		check_bit("update end", 1'b0, delay_update);
		// a frozen clock enable must hold the delay in force
		@(posedge clock);
		clk_en <= 1'b0;
		fine <= 8'h5a;
		tick(3);
		check_vec("frozen fine", 17'hff, 17'(applied_delay.fine));
		@(posedge clock);
		clk_en <= 1'b1;
		tick(2);
		check_vec("fine", 17'h5a, 17'(applied_delay.fine));
		$display("delay_test done");
	endtask : delay_test

	task direct_test;
		wr_coarse(8'hff, 1'b0, 1'b0);
		check_vec("coarse max", 17'hff, 17'(applied_delay.coarse));
		check_bit("no ramp", 1'b0, ramp_busy);
		wr_coarse(8'h10, 1'b0, 1'b0);
		check_vec("coarse", 17'h10, 17'(applied_delay.coarse));
		$display("direct_test done");
	endtask : direct_test

	task fast_ramp_test;
		wr_coarse(8'h12, 1'b1, 1'b1);
		check_vec("target", 17'h12, 17'(coarse_target));
		check_vec("no jump", 17'h10, 17'(applied_delay.coarse));
		check_bit("busy", 1'b1, ramp_busy);
		// step lands 64 edges after the taking edge
		tick(62);
		check_vec("before step", 17'h10, 17'(applied_delay.coarse));
		tick(1);
		check_vec("step 1", 17'h11, 17'(applied_delay.coarse));
		check_bit("step update", 1'b1, delay_update);
		tick(64);
		check_vec("step 2", 17'h12, 17'(applied_delay.coarse));
		tick(1);
		check_bit("ramp done", 1'b0, ramp_busy);
		$display("fast_ramp_test done");
	endtask : fast_ramp_test

	task slow_retarget_test;
		wr_coarse(8'h10, 1'b1, 1'b0);
		// step lands 256 edges after the taking edge
		tick(254);
		check_vec("slow wait", 17'h12, 17'(applied_delay.coarse));
		tick(1);
		check_vec("slow down", 17'h11, 17'(applied_delay.coarse));
		// retarget mid-ramp: the step timer must start again
		wr_coarse(8'h12, 1'b1, 1'b0);
		check_vec("retarget", 17'h12, 17'(coarse_target));
		tick(254);
		check_vec("restart", 17'h11, 17'(applied_delay.coarse));
		tick(1);
		check_vec("slow up", 17'h12, 17'(applied_delay.coarse));
		tick(1);
		check_bit("slow done", 1'b0, ramp_busy);
		$display("slow_retarget_test done");
	endtask : slow_retarget_test

	task sysref_test;
		int cnt;
		@(posedge clock);
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		// filtered level rises 4 edges after the pin, capture one later
		tick(4);
		check_bit("early capture", 1'b0, sysref_capture);
		check_bit("level", 1'b1, sysref_level);
		tick(1);
		check_bit("capture", 1'b1, sysref_capture);
		tick(6);
		check_bit("level held", 1'b1, sysref_level);
		tick(1);
		check_bit("level low", 1'b0, sysref_level);
		@(posedge clock);
		periodic <= 1'b1;
		cnt = 0;
		repeat (128) begin
			tick(1);
			if (sysref_capture === 1'b1) begin
				cnt++;
			end
		end
		check_vec("periodic captures", 17'd4, cnt[16:0]);
		@(posedge clock);
		periodic <= 1'b0;
		$display("sysref_test done");
	endtask : sysref_test

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		reset_edges_test();
		delay_test();
		direct_test();
		fast_ramp_test();
		slow_retarget_test();
		sysref_test();
		wrap_up();
	end

	// the run needs about 820 cycles; the 2000-cycle limit allows more than twice that
	initial begin
		#20000;
		mismatches++;
		wrap_up();
	end
endmodule : test_sampling_delay_ramp_control
